// [verilog/tio_pkg.sv]
package tio_pkg;

	// register map, byte addresses of 32-bit words
	localparam logic [7:0] TIO_OFS_CTRL    = 8'h00;
	localparam logic [7:0] TIO_OFS_DUR     = 8'h04;
	localparam logic [7:0] TIO_OFS_STEP    = 8'h08;
	localparam logic [7:0] TIO_OFS_STATUS  = 8'h0C;

	// step register field positions
	localparam int TIO_STEP_KIND_LSB = 0;
	localparam int TIO_STEP_POL_BIT  = 2;
	localparam int TIO_STEP_LVL_BIT  = 3;
	localparam int TIO_STEP_MODE_LSB = 4;
	localparam int TIO_MODE_W        = 4;

	// step kinds written to the step register
	localparam logic [1:0] TIO_KIND_PULSE = 2'h1;
	localparam logic [1:0] TIO_KIND_WAIT  = 2'h2;
	localparam logic [1:0] TIO_KIND_LEVEL = 2'h3;

	// reset values
	localparam logic       TIO_DEFAULT_RST = 1'h0;
	localparam logic [31:0] TIO_DUR_RST    = 32'h0000_0001;

	// timing: least input hold the far instrument guarantees
	localparam int TIO_CLK_MHZ     = 100;
	localparam int TIO_MIN_HOLD_US = 100;
	localparam int TIO_MIN_HOLD_CYC = TIO_MIN_HOLD_US * TIO_CLK_MHZ;

	typedef enum logic [1:0] {
		TIO_IDLE,
		TIO_PULSE,
		TIO_WAIT
	} tio_state_t;

endpackage

// [verilog/tio_trigger_io.sv]
`timescale 1ns/100ps
module tio_trigger_io
	import tio_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// trigger pins
	input  wire logic        trig_in,
	output logic             trig_out,
	// sequencer side
	output logic             seq_hold,
	output logic [3:0]       ctrl_mode
);

	////////////////////////////////////////////////////////////////////////
	// registers and state

	tio_state_t  state_q;
	logic [31:0] dur_q;
	logic [31:0] cnt_q;
	logic        default_q;
	logic        pulse_pol_q;
	logic        wait_pol_q;
	logic [3:0]  mode_q;
	logic        sync1_q;
	logic        sync2_q;
	logic [31:0] done_cnt_q;
	logic [31:0] pulse_len_q;

	logic        step_wr;
	logic [1:0]  step_kind;
	logic        in_active;

	// all checks below run on sys_clk and sleep while reset is high
	default clocking chk_cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	assign step_wr   = reg_wr && (reg_addr == TIO_OFS_STEP);
	assign step_kind = reg_wdata[TIO_STEP_KIND_LSB +: 2];

	////////////////////////////////////////////////////////////////////////
	// input synchroniser; first stage feeds only the second

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			sync1_q <= 1'h0;
			sync2_q <= 1'h0;
		end else begin
			sync1_q <= trig_in;
			sync2_q <= sync1_q;
		end
	end

	// level compare, no edge detection, so a held level is never missed
	assign in_active = (sync2_q == wait_pol_q);

	////////////////////////////////////////////////////////////////////////
	// duration register, written before each pulse step

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dur_q <= TIO_DUR_RST;
		end else if (reg_wr && reg_addr == TIO_OFS_DUR) begin
			dur_q <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stored default level; only a level step or reset touch it

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			default_q <= TIO_DEFAULT_RST;
		end else if (step_wr && step_kind == TIO_KIND_LEVEL
			&& state_q == TIO_IDLE) begin
			default_q <= reg_wdata[TIO_STEP_LVL_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// step sequencer; steps are refused while one is still running

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q     <= TIO_IDLE;
			cnt_q       <= 32'h0000_0000;
			pulse_pol_q <= 1'h1;
			wait_pol_q  <= 1'h1;
			mode_q      <= 4'h0;
		end else begin
			unique case (state_q)
				TIO_IDLE: begin
					if (step_wr && step_kind == TIO_KIND_PULSE) begin
						pulse_pol_q <= reg_wdata[TIO_STEP_POL_BIT];
						// zero duration still gives a one-cycle pulse
						cnt_q   <= (dur_q == 32'h0) ? 32'h1 : dur_q;
						state_q <= TIO_PULSE;
					end else if (step_wr && step_kind == TIO_KIND_WAIT) begin
						wait_pol_q <= reg_wdata[TIO_STEP_POL_BIT];
						// next step's mode is applied at once
						mode_q  <= reg_wdata[TIO_STEP_MODE_LSB +: TIO_MODE_W];
						state_q <= TIO_WAIT;
					end
				end
				TIO_PULSE: begin
					cnt_q <= cnt_q - 32'h1;
					if (cnt_q == 32'h1) begin
						state_q <= TIO_IDLE;
					end
				end
				TIO_WAIT: begin
					if (in_active) begin
						state_q <= TIO_IDLE;
					end
				end
				default: state_q <= TIO_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered outputs

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			trig_out  <= TIO_DEFAULT_RST;
			seq_hold  <= 1'h0;
			ctrl_mode <= 4'h0;
		end else begin
			// pulse level while counting, default otherwise
			if (state_q == TIO_PULSE && cnt_q != 32'h1) begin
				trig_out <= pulse_pol_q;
			end else if (state_q == TIO_IDLE && step_wr
				&& step_kind == TIO_KIND_PULSE) begin
				trig_out <= reg_wdata[TIO_STEP_POL_BIT];
			end else if (state_q == TIO_IDLE && step_wr
				&& step_kind == TIO_KIND_LEVEL) begin
				trig_out <= reg_wdata[TIO_STEP_LVL_BIT];
			end else begin
				trig_out <= default_q;
			end
			seq_hold  <= (state_q == TIO_WAIT) ? !in_active
				: (state_q == TIO_IDLE && step_wr
				&& step_kind == TIO_KIND_WAIT);
			ctrl_mode <= (state_q == TIO_IDLE && step_wr
				&& step_kind == TIO_KIND_WAIT)
				? reg_wdata[TIO_STEP_MODE_LSB +: TIO_MODE_W]
				: mode_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data valid the cycle after the strobe

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				TIO_OFS_CTRL:   reg_rdata <= {28'h0, mode_q};
				TIO_OFS_DUR:    reg_rdata <= dur_q;
				TIO_OFS_STEP:   reg_rdata <= {31'h0, default_q};
				TIO_OFS_STATUS: reg_rdata <= {27'h0, sync2_q, wait_pol_q,
					pulse_pol_q, state_q};
				default:        reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			done_cnt_q <= 32'h0;
		end else begin
			done_cnt_q <= (state_q == TIO_PULSE) ? done_cnt_q + 32'h1 : 32'h0;
		end
	end

	// duration as it stood when the pulse began; software may rewrite
	// the duration register mid-pulse without touching the running one
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pulse_len_q <= 32'h0;
		end else if (state_q == TIO_IDLE && step_wr
			&& step_kind == TIO_KIND_PULSE) begin
			pulse_len_q <= dur_q;
		end
	end

	sequence s_pulse_start;
		state_q == TIO_IDLE && step_wr && step_kind == TIO_KIND_PULSE;
	endsequence

	a_pulse_level: assert property (
		s_pulse_start |=> trig_out == $past(reg_wdata[TIO_STEP_POL_BIT]))
		else $error("pulse level wrong");

	a_pulse_length: assert property (
		state_q == TIO_PULSE && cnt_q == 32'h1
		|-> done_cnt_q + 32'h1 == pulse_len_q
		|| pulse_len_q == 32'h0 && done_cnt_q == 32'h0)
		else $error("pulse length wrong");

	a_idle_default: assert property (
		state_q == TIO_IDLE && $past(state_q) == TIO_IDLE && !$past(step_wr)
		|-> trig_out == default_q)
		else $error("output not at default");

	a_default_keep: assert property (
		!$past(step_wr) |-> $stable(default_q))
		else $error("default changed without step");

	// hold is registered, so it is looked at in the cycle after the test
	a_wait_hold: assert property (
		state_q == TIO_WAIT && !in_active |=> state_q == TIO_WAIT && seq_hold)
		else $error("wait left early");

	a_wait_release: assert property (
		state_q == TIO_WAIT && in_active |=> state_q == TIO_IDLE && !seq_hold)
		else $error("wait not released");

	a_wait_mode: assert property (
		state_q == TIO_WAIT |-> ctrl_mode == mode_q)
		else $error("mode not applied");

	// the stages are cleared by reset, so only pin values taken after it
	// are expected to come out of the second stage
	a_sync_depth: assert property (
		!$past(reset, 2) |-> sync2_q == $past(trig_in, 2))
		else $error("synchroniser depth wrong");

endmodule

// [tb/tio_instr_model.sv]
`timescale 1ns/100ps
////////////////////////////////////////
// far instrument: drives its trigger to the requested level pol on request
module tio_instr_model
	import tio_pkg::*;
#(
	parameter int HOLD_CYC = TIO_MIN_HOLD_CYC
)(
	// clock
	input  wire logic sys_clk,
	// bench commands
	input  wire logic fire,
	input  wire logic pol,
	// trigger line
	output logic      trig_in
);
	int hold_cnt = 0;
	initial trig_in = 1'b0;
	// a new request is taken only once the last span ran out
	always @(posedge sys_clk) begin
		if (fire && hold_cnt == 0)
			hold_cnt <= HOLD_CYC;
		else if (hold_cnt != 0)
			hold_cnt <= hold_cnt - 1;
	end
	// inactive level whenever no span runs, so no stale value lingers
	always @(posedge sys_clk)
		trig_in <= #2 (fire || hold_cnt > 1) ? pol : ~pol;
endmodule

// [tb/tio_trigger_io_tb_top.sv]
`timescale 1ns/100ps
module tio_trigger_io_tb_top;
	import tio_pkg::*;
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        trig_in;
	logic        trig_out;
	logic        seq_hold;
	logic [3:0]  ctrl_mode;
	logic        fire = 1'b0;
	logic        mdl_pol = 1'b0;
	int          err_count = 0;
	int          n_checks = 0;
	////////////////////////////////////////
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	// block and far instrument
	tio_trigger_io dut_u (.sys_clk(sys_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_in(trig_in),
		.trig_out(trig_out), .seq_hold(seq_hold), .ctrl_mode(ctrl_mode));
	tio_instr_model mdl_u (.sys_clk(sys_clk), .fire(fire), .pol(mdl_pol),
		.trig_in(trig_in));
	////////////////////////////////////////
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string w);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(w, e, reg_rdata);
	endtask
	task automatic pulse_chk(input logic p, input logic dl, input int n);
		wr(TIO_OFS_DUR, 32'(n));
		wr(TIO_OFS_STEP, {29'h0, p, TIO_KIND_PULSE});
		for (int i = 0; i < n; i++) begin
			#1;
			chk("pulse level", 32'(p), 32'(trig_out));
			@(posedge sys_clk);
		end
		#1;
		chk("rest level", 32'(dl), 32'(trig_out));
	endtask
	// bounded wait for the sequence to be let go
	task automatic release_chk();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (seq_hold !== 1'b0 && n < 8);
		chk("release", 32'h0, 32'(seq_hold));
	endtask
	task automatic wait_chk(input logic p, input logic [3:0] m,
		input logic dl);
		mdl_pol <= p;
		repeat (4) @(posedge sys_clk);
		wr(TIO_OFS_STEP, {24'h0, m, 1'b0, p, TIO_KIND_WAIT});
		#1;
		chk("hold", 32'h1, 32'(seq_hold));
		chk("mode", 32'(m), 32'(ctrl_mode));
		wr(TIO_OFS_STEP, {29'h0, ~dl, TIO_KIND_PULSE});
		repeat (20) @(posedge sys_clk);
		#1;
		chk("busy pulse", 32'(dl), 32'(trig_out));
		chk("still held", 32'h1, 32'(seq_hold));
		@(posedge sys_clk);
		fire <= 1'b1;
		@(posedge sys_clk);
		fire <= 1'b0;
		release_chk();
		wr(TIO_OFS_STEP, {24'h0, m, 1'b0, p, TIO_KIND_WAIT});
		release_chk();
		repeat (TIO_MIN_HOLD_CYC + 8) @(posedge sys_clk);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////
	// watchdog sized well past the two long waits
	initial begin
		#(40000 * 10);
		err_count++;
		end_sim();
	end
	// test sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk("reset level", 32'h0, 32'(trig_out));
		rd(TIO_OFS_STEP, 32'h0, "default");
		rd(TIO_OFS_DUR, 32'h1, "dur reset");
		$display("test reset done");
		pulse_chk(1'b1, 1'b0, 3);
		wr(TIO_OFS_STEP, {28'h0, 1'b1, 1'b0, TIO_KIND_LEVEL});
		#1;
		chk("level high", 32'h1, 32'(trig_out));
		rd(TIO_OFS_STEP, 32'h1, "default");
		pulse_chk(1'b0, 1'b1, 5);
		$display("test pulses done");
		wait_chk(1'b1, 4'h5, 1'b1);
		wait_chk(1'b0, 4'hA, 1'b1);
		rd(TIO_OFS_STEP, 32'h1, "default kept");
		rd(TIO_OFS_CTRL, 32'hA, "mode");
		rd(TIO_OFS_STATUS, 32'h10, "status");
		rd(8'h40, 32'h0, "unmapped");
		$display("test waits done");
		// a second reset must bring the stored default back to 0
		@(posedge sys_clk);
		reset <= 1'b1;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		#1;
		chk("reset level", 32'h0, 32'(trig_out));
		rd(TIO_OFS_STEP, 32'h0, "default");
		$display("test second reset done");
		end_sim();
	end
endmodule
